// ===== core/i2cmd_two_wire_master.sv
// Two-wire master with RAM buffer sequencing and an Avalon-MM register slave
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module i2cmd_two_wire_master (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	// Avalon-MM register slave
	input  wire logic [11:0] avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// RAM buffer port, read data valid one cycle after ram_rd
	output logic             ram_rd,
	output logic             ram_wr,
	output logic      [31:0] ram_addr,
	output logic      [7:0]  ram_wdata,
	input  wire logic [7:0]  ram_rdata,
	// Two-wire pins, open drain
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe,
	// Pin routing and interrupt
	output logic      [31:0] scl_pin_sel,
	output logic      [31:0] sda_pin_sel,
	output logic             pin_route_en,
	output logic             irq
);
	typedef struct packed {
		logic                   scl_m, scl_s, sda_m, sda_s;
		logic                   ack;
		logic [31:0]            rdata;
		logic [7:0]             div;
		i2cmd_pkg::i2cmd_state_type st;
		i2cmd_pkg::i2cmd_seg_type   seg, cont_seg;
		logic [1:0]             q;
		logic [2:0]             bitn;
		logic [7:0]             sh;
		logic                   ackin, rnack, load;
		logic                   scl_low, sda_low;
		logic                   dir_rx, susp, susp_pend, stop_pend, start_pend, start_rx, cont;
		logic [31:0]            tx_ptr, rx_ptr, addr;
		logic [i2cmd_pkg::CNT_W-1:0] tx_lim, rx_lim, lim, cnt, tx_amt, rx_amt;
		logic [1:0]             rx_list, tx_list, rate;
		logic [12:0]            links;
		logic [31:0]            irq_mask;
		logic [i2cmd_pkg::EV_NUM-1:0] flags, ev;
		logic [2:0]             fault;
		logic                   enable;
		logic [31:0]            scl_sel, sda_sel;
		logic [6:0]             slave;
		logic                   ram_rd, ram_wr;
		logic [31:0]            ram_addr;
		logic [7:0]             ram_wdata;
	} i2cmd_regs_type;

	i2cmd_regs_type s, n;
	logic wr_ok, tick, t_rx, t_tx, t_halt, t_pause, t_cont;
	logic [7:0] qmax;
	logic [31:0] pend;
	logic [i2cmd_pkg::CNT_W-1:0] cnt1;

	// Bus handshake: one wait cycle, then the answer
	assign avs_waitrequest = (avs_read | avs_write) & ~s.ack;
	assign wr_ok = avs_write & s.ack;
	// Task pulses from software writes and event links
	assign t_rx = (wr_ok && avs_address == i2cmd_pkg::OFS_BEGIN_RX && avs_writedata[0])
		| (s.ev[i2cmd_pkg::EV_FINTX] & s.links[i2cmd_pkg::LNK_FTX_RX]);
	assign t_tx = (wr_ok && avs_address == i2cmd_pkg::OFS_BEGIN_TX && avs_writedata[0])
		| (s.ev[i2cmd_pkg::EV_FINRX] & s.links[i2cmd_pkg::LNK_FRX_TX]);
	assign t_halt = (wr_ok && avs_address == i2cmd_pkg::OFS_HALT && avs_writedata[0])
		| (s.ev[i2cmd_pkg::EV_FINTX] & s.links[i2cmd_pkg::LNK_FTX_HALT])
		| (s.ev[i2cmd_pkg::EV_FINRX] & s.links[i2cmd_pkg::LNK_FRX_HALT]);
	assign t_pause = (wr_ok && avs_address == i2cmd_pkg::OFS_PAUSE && avs_writedata[0])
		| (s.ev[i2cmd_pkg::EV_FINTX] & s.links[i2cmd_pkg::LNK_FTX_PAUS])
		| (s.ev[i2cmd_pkg::EV_FINRX] & s.links[i2cmd_pkg::LNK_FRX_PAUS]);
	assign t_cont = wr_ok && avs_address == i2cmd_pkg::OFS_CONTINUE && avs_writedata[0];
	// Quarter-bit length from the selected rate
	assign qmax = (s.rate == i2cmd_pkg::RATE_K250) ? 8'(i2cmd_pkg::Q250 - 1) :
		(s.rate == i2cmd_pkg::RATE_K400) ? 8'(i2cmd_pkg::Q400 - 1) :
		8'(i2cmd_pkg::Q100 - 1);
	assign tick = (s.div == qmax);
	assign cnt1 = s.cnt + 1'b1;

	// Pending interrupt sources and outputs
	always_comb begin
		pend = '0;
		for (int i = 0; i < i2cmd_pkg::EV_NUM; i++) begin
			pend[i2cmd_pkg::IRQ_BIT[i]] = s.flags[i];
		end
	end
	assign irq = |(pend & s.irq_mask);
	assign avs_readdata = s.rdata;
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe = s.enable & s.scl_low;
	assign sda_oe = s.enable & s.sda_low;
	assign scl_pin_sel = s.scl_sel;
	assign sda_pin_sel = s.sda_sel;
	assign pin_route_en = s.enable;
	assign ram_rd = s.ram_rd;
	assign ram_wr = s.ram_wr;
	assign ram_addr = s.ram_addr;
	assign ram_wdata = s.ram_wdata;

	// Next-state logic for bus slave, tasks and the bit sequencer
	always_comb begin
		n = s;
		n.scl_m = scl_i;
		n.scl_s = s.scl_m;
		n.sda_m = sda_i;
		n.sda_s = s.sda_m;
		n.ack = (avs_read | avs_write) & ~s.ack;
		n.div = tick ? 8'h00 : s.div + 8'h01;
		n.ev = '0;
		n.ram_rd = 1'b0;
		n.ram_wr = 1'b0;
		n.load = s.ram_rd;
		if (s.load) begin
			n.sh = ram_rdata;
		end
		// Register reads
		if (avs_read & ~s.ack) begin
			n.rdata = 32'h00000000;
			unique case (avs_address)
				i2cmd_pkg::OFS_HALTED:    n.rdata[0] = s.flags[i2cmd_pkg::EV_HALTED];
				i2cmd_pkg::OFS_FAULT:     n.rdata[0] = s.flags[i2cmd_pkg::EV_FAULT];
				i2cmd_pkg::OFS_PAUSED:    n.rdata[0] = s.flags[i2cmd_pkg::EV_PAUSED];
				i2cmd_pkg::OFS_RX_BEGUN:  n.rdata[0] = s.flags[i2cmd_pkg::EV_RXBEG];
				i2cmd_pkg::OFS_TX_BEGUN:  n.rdata[0] = s.flags[i2cmd_pkg::EV_TXBEG];
				i2cmd_pkg::OFS_FINAL_RX:  n.rdata[0] = s.flags[i2cmd_pkg::EV_FINRX];
				i2cmd_pkg::OFS_FINAL_TX:  n.rdata[0] = s.flags[i2cmd_pkg::EV_FINTX];
				i2cmd_pkg::OFS_LINKS:     n.rdata[12:0] = s.links;
				i2cmd_pkg::OFS_IRQ_MASK,
				i2cmd_pkg::OFS_IRQ_SET,
				i2cmd_pkg::OFS_IRQ_CLR:   n.rdata = s.irq_mask;
				i2cmd_pkg::OFS_FAULT_SRC: n.rdata[2:0] = s.fault;
				i2cmd_pkg::OFS_ENABLE:    n.rdata[0] = s.enable;
				i2cmd_pkg::OFS_SCL_SEL:   n.rdata = s.scl_sel;
				i2cmd_pkg::OFS_SDA_SEL:   n.rdata = s.sda_sel;
				i2cmd_pkg::OFS_RATE:      n.rdata[1:0] = s.rate;
				i2cmd_pkg::OFS_RX_PTR:    n.rdata = s.rx_ptr;
				i2cmd_pkg::OFS_RX_LIMIT:  n.rdata[15:0] = s.rx_lim;
				i2cmd_pkg::OFS_RX_MOVED:  n.rdata[15:0] = s.rx_amt;
				i2cmd_pkg::OFS_RX_LIST:   n.rdata[1:0] = s.rx_list;
				i2cmd_pkg::OFS_TX_PTR:    n.rdata = s.tx_ptr;
				i2cmd_pkg::OFS_TX_LIMIT:  n.rdata[15:0] = s.tx_lim;
				i2cmd_pkg::OFS_TX_MOVED:  n.rdata[15:0] = s.tx_amt;
				i2cmd_pkg::OFS_TX_LIST:   n.rdata[1:0] = s.tx_list;
				i2cmd_pkg::OFS_SLAVE:     n.rdata[6:0] = s.slave;
				default:                  n.rdata = 32'h00000000;
			endcase
		end
		// Register writes; flags take the written value, fresh events win below
		if (wr_ok) begin
			unique case (avs_address)
				i2cmd_pkg::OFS_HALTED:    n.flags[i2cmd_pkg::EV_HALTED] = avs_writedata[0];
				i2cmd_pkg::OFS_FAULT:     n.flags[i2cmd_pkg::EV_FAULT] = avs_writedata[0];
				i2cmd_pkg::OFS_PAUSED:    n.flags[i2cmd_pkg::EV_PAUSED] = avs_writedata[0];
				i2cmd_pkg::OFS_RX_BEGUN:  n.flags[i2cmd_pkg::EV_RXBEG] = avs_writedata[0];
				i2cmd_pkg::OFS_TX_BEGUN:  n.flags[i2cmd_pkg::EV_TXBEG] = avs_writedata[0];
				i2cmd_pkg::OFS_FINAL_RX:  n.flags[i2cmd_pkg::EV_FINRX] = avs_writedata[0];
				i2cmd_pkg::OFS_FINAL_TX:  n.flags[i2cmd_pkg::EV_FINTX] = avs_writedata[0];
				i2cmd_pkg::OFS_LINKS:     n.links = avs_writedata[12:0];
				i2cmd_pkg::OFS_IRQ_MASK:  n.irq_mask = avs_writedata;
				i2cmd_pkg::OFS_IRQ_SET:   n.irq_mask = s.irq_mask | avs_writedata;
				i2cmd_pkg::OFS_IRQ_CLR:   n.irq_mask = s.irq_mask & ~avs_writedata;
				i2cmd_pkg::OFS_FAULT_SRC: n.fault = s.fault & ~avs_writedata[2:0];
				i2cmd_pkg::OFS_ENABLE:    n.enable = avs_writedata[0];
				i2cmd_pkg::OFS_SCL_SEL:   n.scl_sel = avs_writedata;
				i2cmd_pkg::OFS_SDA_SEL:   n.sda_sel = avs_writedata;
				i2cmd_pkg::OFS_RATE:      n.rate = avs_writedata[1:0];
				i2cmd_pkg::OFS_RX_PTR:    n.rx_ptr = avs_writedata;
				i2cmd_pkg::OFS_RX_LIMIT:  n.rx_lim = avs_writedata[15:0];
				i2cmd_pkg::OFS_RX_LIST:   n.rx_list = avs_writedata[1:0];
				i2cmd_pkg::OFS_TX_PTR:    n.tx_ptr = avs_writedata;
				i2cmd_pkg::OFS_TX_LIMIT:  n.tx_lim = avs_writedata[15:0];
				i2cmd_pkg::OFS_TX_LIST:   n.tx_list = avs_writedata[1:0];
				i2cmd_pkg::OFS_SLAVE:     n.slave = avs_writedata[6:0];
				default: ;
			endcase
		end
		// Tasks that latch a request; halt in ST_IDLE, pause in ST_HOLD and continue act at once
		if (t_halt && !s.susp) begin
			if (s.st == i2cmd_pkg::ST_IDLE) begin
				n.ev[i2cmd_pkg::EV_HALTED] = 1'b1;
			end else begin
				n.stop_pend = 1'b1;
			end
		end
		if (t_pause && s.st != i2cmd_pkg::ST_IDLE) begin
			if (s.st == i2cmd_pkg::ST_HOLD) begin
				n.susp = 1'b1;
				n.ev[i2cmd_pkg::EV_PAUSED] = !s.susp;
			end else begin
				n.susp_pend = 1'b1;
			end
		end
		if (t_cont) begin
			n.susp = 1'b0;
			n.susp_pend = 1'b0;
		end
		if ((t_rx | t_tx) && s.st != i2cmd_pkg::ST_IDLE) begin
			n.start_pend = 1'b1;
			n.start_rx = t_rx;
		end
		// Sequencer
		unique case (s.st)
			i2cmd_pkg::ST_IDLE: begin
				n.scl_low = 1'b0;
				n.sda_low = 1'b0;
				if ((t_rx | t_tx) && s.enable) begin
					n.st = i2cmd_pkg::ST_START;
					n.q = 2'h0;
					n.start_rx = t_rx;
					n.start_pend = 1'b1;
				end
			end
			i2cmd_pkg::ST_START: if (tick) begin
				unique case (s.q)
					2'h0: begin
						n.sda_low = 1'b0;
						n.q = 2'h1;
						n.start_pend = 1'b0;
						n.dir_rx = s.start_rx;
						n.cnt = '0;
						n.addr = s.start_rx ? s.rx_ptr : s.tx_ptr;
						n.lim = s.start_rx ? s.rx_lim : s.tx_lim;
						if (s.start_rx) begin
							n.rx_amt = '0;
							n.ev[i2cmd_pkg::EV_RXBEG] = 1'b1;
						end else begin
							n.tx_amt = '0;
							n.ev[i2cmd_pkg::EV_TXBEG] = 1'b1;
						end
					end
					2'h1: begin
						n.scl_low = 1'b0;
						n.q = 2'h2;
					end
					2'h2: if (s.scl_s) begin
						n.sda_low = 1'b1;
						n.q = 2'h3;
					end
					2'h3: begin
						n.st = i2cmd_pkg::ST_BIT;
						n.seg = i2cmd_pkg::SG_ADDR;
						n.sh = {s.slave, s.dir_rx};
						n.bitn = 3'h7;
						n.q = 2'h0;
					end
				endcase
			end
			i2cmd_pkg::ST_BIT: if (tick) begin
				unique case (s.q)
					2'h0: begin
						n.scl_low = 1'b1;
						n.q = 2'h1;
					end
					2'h1: begin
						n.scl_low = 1'b0;
						n.q = 2'h2;
					end
					2'h2: if (s.scl_s) begin
						n.q = 2'h3;
						n.ackin = s.sda_s;
						if (s.seg == i2cmd_pkg::SG_RXD) begin
							n.sh = {s.sh[6:0], s.sda_s};
						end
					end
					2'h3: begin
						n.q = 2'h0;
						if ((s.seg == i2cmd_pkg::SG_ADDR || s.seg == i2cmd_pkg::SG_TXD ||
							s.seg == i2cmd_pkg::SG_RXD) && s.bitn != 3'h0) begin
							n.bitn = s.bitn - 3'h1;
							if (s.seg != i2cmd_pkg::SG_RXD) begin
								n.sh = {s.sh[6:0], 1'b0};
							end
						end else begin
							n.bitn = 3'h7;
							unique case (s.seg)
								i2cmd_pkg::SG_ADDR: n.seg = i2cmd_pkg::SG_AACK;
								i2cmd_pkg::SG_TXD:  n.seg = i2cmd_pkg::SG_TACK;
								i2cmd_pkg::SG_RXD: begin
									n.seg = i2cmd_pkg::SG_RACK;
									n.cnt = cnt1;
									n.rx_amt = cnt1;
									n.ram_wr = 1'b1;
									n.ram_addr = s.addr;
									n.ram_wdata = s.sh;
									n.addr = s.addr + 32'h1;
									n.rnack = (cnt1 == s.lim) | s.stop_pend;
								end
								default: begin
									// Byte boundary after an acknowledge bit
									n.cont = 1'b0;
									n.st = i2cmd_pkg::ST_HOLD;
									if ((s.seg != i2cmd_pkg::SG_RACK) &&
										s.ackin == i2cmd_pkg::BIT_NACK) begin
										n.ev[i2cmd_pkg::EV_FAULT] = 1'b1;
										if (s.seg == i2cmd_pkg::SG_AACK) begin
											n.fault[i2cmd_pkg::FC_ADDR_NACK] = 1'b1;
										end else begin
											n.fault[i2cmd_pkg::FC_DATA_NACK] = 1'b1;
										end
									end else if (s.seg == i2cmd_pkg::SG_RACK) begin
										n.cont = !s.rnack;
										n.cont_seg = i2cmd_pkg::SG_RXD;
										n.ev[i2cmd_pkg::EV_FINRX] = !s.rnack &&
											(cnt1 == s.lim);
									end else if (s.dir_rx) begin
										n.cont = (s.lim != '0);
										n.cont_seg = i2cmd_pkg::SG_RXD;
										n.ev[i2cmd_pkg::EV_FINRX] =
											(s.lim == 16'h0001);
									end else begin
										if (s.seg == i2cmd_pkg::SG_TACK) begin
											n.cnt = cnt1;
											n.tx_amt = cnt1;
										end
										if (n.cnt != s.lim) begin
											n.cont = 1'b1;
											n.cont_seg = i2cmd_pkg::SG_TXD;
											n.ram_rd = 1'b1;
											n.ram_addr = s.addr;
											n.addr = s.addr + 32'h1;
											n.ev[i2cmd_pkg::EV_FINTX] =
												(n.cnt + 1'b1 == s.lim);
										end
									end
									if (n.cont && !s.stop_pend && !s.start_pend &&
										!s.susp_pend) begin
										n.st = i2cmd_pkg::ST_BIT;
										n.seg = n.cont_seg;
									end else if (s.susp_pend && !s.stop_pend &&
										!s.start_pend) begin
										n.susp = 1'b1;
										n.scl_low = 1'b1;
										n.susp_pend = 1'b0;
										n.ev[i2cmd_pkg::EV_PAUSED] = 1'b1;
									end
								end
							endcase
						end
					end
				endcase
			end
			i2cmd_pkg::ST_HOLD: begin
				n.scl_low = 1'b1;
				if (tick && !n.susp) begin
					if (s.stop_pend) begin
						n.st = i2cmd_pkg::ST_STOP;
						n.q = 2'h0;
					end else if (s.start_pend) begin
						n.st = i2cmd_pkg::ST_START;
						n.q = 2'h0;
					end else if (s.cont) begin
						n.st = i2cmd_pkg::ST_BIT;
						n.seg = s.cont_seg;
						n.q = 2'h0;
					end
				end
			end
			i2cmd_pkg::ST_STOP: if (tick) begin
				unique case (s.q)
					2'h0: begin
						n.scl_low = 1'b1;
						n.sda_low = 1'b1;
						n.q = 2'h1;
					end
					2'h1: begin
						n.scl_low = 1'b0;
						n.q = 2'h2;
					end
					2'h2: if (s.scl_s) begin
						n.q = 2'h3;
					end
					2'h3: begin
						n.sda_low = 1'b0;
						n.st = i2cmd_pkg::ST_IDLE;
						n.stop_pend = 1'b0;
						n.start_pend = 1'b0;
						n.susp_pend = 1'b0;
						n.ev[i2cmd_pkg::EV_HALTED] = 1'b1;
					end
				endcase
			end
			default: n.st = i2cmd_pkg::ST_IDLE;
		endcase
		// Data moves one cycle after SCL falls, so it never changes beside a clock edge
		if (s.st == i2cmd_pkg::ST_BIT && s.q == 2'h1 && s.div == 8'h00) begin
			if (s.seg == i2cmd_pkg::SG_ADDR || s.seg == i2cmd_pkg::SG_TXD) begin
				n.sda_low = ~s.sh[7];
			end else if (s.seg == i2cmd_pkg::SG_RACK) begin
				n.sda_low = (s.rnack == i2cmd_pkg::BIT_ACK);
			end else begin
				n.sda_low = 1'b0;
			end
		end
		// Fresh events win over a software clear in the same cycle
		n.flags = n.flags | s.ev;
	end

	// State register
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// Checks
	sequence seq_stop_cmd;
		t_halt && s.susp;
	endsequence
	chk_halt_paused: assert property (@(posedge sys_clk) disable iff (sys_rst)
		seq_stop_cmd and !s.stop_pend |=> !s.stop_pend) else $error("halt taken while paused");
	chk_addr_frame: assert property (@(posedge sys_clk) disable iff (sys_rst)
		s.st == i2cmd_pkg::ST_START && n.st == i2cmd_pkg::ST_BIT |=> s.sh == {s.slave, s.dir_rx})
		else $error("address frame wrong");
	chk_nack_fault: assert property (@(posedge sys_clk) disable iff (sys_rst)
		s.st == i2cmd_pkg::ST_BIT && s.seg == i2cmd_pkg::SG_AACK && s.q == 2'h3 && tick
		&& s.ackin |=> ##1 s.flags[i2cmd_pkg::EV_FAULT] && s.fault[i2cmd_pkg::FC_ADDR_NACK])
		else $error("nack did not raise fault");
	chk_halt_event: assert property (@(posedge sys_clk) disable iff (sys_rst)
		s.st == i2cmd_pkg::ST_STOP && s.q == 2'h3 && tick |=> s.ev[i2cmd_pkg::EV_HALTED]
		##1 s.flags[i2cmd_pkg::EV_HALTED]) else $error("halted event missing");
	chk_byte_limit: assert property (@(posedge sys_clk) disable iff (sys_rst)
		s.st != i2cmd_pkg::ST_IDLE && s.st != i2cmd_pkg::ST_START |-> s.cnt <= s.lim)
		else $error("byte count above limit");
	chk_pause_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
		s.susp && s.enable |-> s.st == i2cmd_pkg::ST_HOLD && scl_oe) else $error("pause lost");
	chk_no_self_stop: assert property (@(posedge sys_clk) disable iff (sys_rst)
		s.st != i2cmd_pkg::ST_STOP ##1 s.st == i2cmd_pkg::ST_STOP |-> $past(s.stop_pend))
		else $error("stopped without halt task");
	chk_irq_raise: assert property (@(posedge sys_clk) disable iff (sys_rst)
		s.ev[i2cmd_pkg::EV_FAULT] && s.irq_mask[9] |=> irq) else $error("interrupt missing");
	chk_bus_answer: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest) else $error("bus answer late");
	chk_pins_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!s.enable |-> !scl_oe && !sda_oe) else $error("pins driven while disabled");
endmodule
`default_nettype wire

// ===== core/i2cmd_pkg.sv
// Constants and types shared by the two-wire master sequencer
package i2cmd_pkg;
	// Register byte offsets
	localparam logic [11:0] OFS_BEGIN_RX  = 12'h000;
	localparam logic [11:0] OFS_BEGIN_TX  = 12'h008;
	localparam logic [11:0] OFS_HALT      = 12'h014;
	localparam logic [11:0] OFS_PAUSE     = 12'h01C;
	localparam logic [11:0] OFS_CONTINUE  = 12'h020;
	localparam logic [11:0] OFS_EV_FIRST  = 12'h104;
	localparam logic [11:0] OFS_HALTED    = 12'h104;
	localparam logic [11:0] OFS_FAULT     = 12'h124;
	localparam logic [11:0] OFS_PAUSED    = 12'h148;
	localparam logic [11:0] OFS_RX_BEGUN  = 12'h14C;
	localparam logic [11:0] OFS_TX_BEGUN  = 12'h150;
	localparam logic [11:0] OFS_FINAL_RX  = 12'h15C;
	localparam logic [11:0] OFS_FINAL_TX  = 12'h160;
	localparam logic [11:0] OFS_LINKS     = 12'h200;
	localparam logic [11:0] OFS_IRQ_MASK  = 12'h300;
	localparam logic [11:0] OFS_IRQ_SET   = 12'h304;
	localparam logic [11:0] OFS_IRQ_CLR   = 12'h308;
	localparam logic [11:0] OFS_FAULT_SRC = 12'h4C4;
	localparam logic [11:0] OFS_ENABLE    = 12'h500;
	localparam logic [11:0] OFS_SCL_SEL   = 12'h508;
	localparam logic [11:0] OFS_SDA_SEL   = 12'h50C;
	localparam logic [11:0] OFS_RATE      = 12'h524;
	localparam logic [11:0] OFS_RX_PTR    = 12'h534;
	localparam logic [11:0] OFS_RX_LIMIT  = 12'h538;
	localparam logic [11:0] OFS_RX_MOVED  = 12'h53C;
	localparam logic [11:0] OFS_RX_LIST   = 12'h540;
	localparam logic [11:0] OFS_TX_PTR    = 12'h544;
	localparam logic [11:0] OFS_TX_LIMIT  = 12'h548;
	localparam logic [11:0] OFS_TX_MOVED  = 12'h54C;
	localparam logic [11:0] OFS_TX_LIST   = 12'h550;
	localparam logic [11:0] OFS_SLAVE     = 12'h588;
	// Event indices inside the event vector
	localparam int EV_HALTED = 0;
	localparam int EV_FAULT  = 1;
	localparam int EV_PAUSED = 2;
	localparam int EV_RXBEG  = 3;
	localparam int EV_TXBEG  = 4;
	localparam int EV_FINRX  = 5;
	localparam int EV_FINTX  = 6;
	localparam int EV_NUM    = 7;
	// Interrupt mask bit position of each event, in event index order
	localparam int IRQ_BIT [EV_NUM] = '{1, 9, 18, 19, 20, 23, 24};
	// Event-to-task link bits
	localparam int LNK_FTX_RX   = 7;
	localparam int LNK_FTX_PAUS = 8;
	localparam int LNK_FTX_HALT = 9;
	localparam int LNK_FRX_TX   = 10;
	localparam int LNK_FRX_PAUS = 11;
	localparam int LNK_FRX_HALT = 12;
	// Fault cause bits
	localparam int FC_ADDR_NACK = 1;
	localparam int FC_DATA_NACK = 2;
	// Bus bit levels and rate codes
	localparam logic DIR_WRITE = 1'b0;
	localparam logic DIR_READ  = 1'b1;
	localparam logic BIT_ACK   = 1'b0;
	localparam logic BIT_NACK  = 1'b1;
	localparam logic [1:0] RATE_K100 = 2'h0;
	localparam logic [1:0] RATE_K250 = 2'h1;
	localparam logic [1:0] RATE_K400 = 2'h2;
	// Timing: clock and bit rates, quarter-bit counts rounded up
	localparam int SYS_CLK_HZ = 100000000;
	localparam int RATE_100_BPS = 100000;
	localparam int RATE_250_BPS = 250000;
	localparam int RATE_400_BPS = 400000;
	localparam int Q100 = (SYS_CLK_HZ + 4 * RATE_100_BPS - 1) / (4 * RATE_100_BPS);
	localparam int Q250 = (SYS_CLK_HZ + 4 * RATE_250_BPS - 1) / (4 * RATE_250_BPS);
	localparam int Q400 = (SYS_CLK_HZ + 4 * RATE_400_BPS - 1) / (4 * RATE_400_BPS);
	localparam int CNT_W = 16;
	// Sequencer states and bit segments
	typedef enum logic [2:0] {ST_IDLE, ST_START, ST_BIT, ST_HOLD, ST_STOP} i2cmd_state_type;
	typedef enum logic [2:0] {SG_ADDR, SG_AACK, SG_TXD, SG_TACK, SG_RXD, SG_RACK} i2cmd_seg_type;
endpackage

// ===== dv/i2cmd_slave_model.sv
// Behavioural two-wire slave: acks and answers reads with a fixed byte
`timescale 1ns/10ps
`default_nettype none
module i2cmd_slave_model #(
	parameter logic [7:0] RD_BYTE = 8'hA5
) (
	// Bus lines and fault control
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic       nack_en,
	// Pull and observed bytes
	output logic            sda_pull,
	output logic [7:0]      addr_byte,
	output logic [7:0]      last_byte
);
	int         bitn = 0;
	logic       first = 1'b1;
	logic       rd = 1'b0;
	logic [7:0] sh = 8'h00;
	initial sda_pull = 1'b0;
	// Start condition restarts the frame
	always @(negedge sda) if (scl) begin
		bitn = 0;
		first = 1'b1;
	end
	// Sample on the rising clock, MSB first
	always @(posedge scl) begin
		sh = {sh[6:0], sda};
		bitn = bitn + 1;
		if (bitn == 8 && first) begin
			addr_byte = sh;
			rd = sh[0];
		end else if (bitn == 8) last_byte = sh;
	end
	// Change data only while the clock is low; released line floats high
	always @(negedge scl) begin
		if (bitn == 9) begin
			bitn = 0;
			first = 1'b0;
		end
		if (bitn == 8) sda_pull = first ? !nack_en : !rd;
		else sda_pull = rd & !first & !RD_BYTE[7 - bitn];
	end
endmodule
`default_nettype wire

// ===== dv/test_i2c_master_dma_sequencer.sv
// Register-driven bench for the two-wire master sequencer
`timescale 1ns/10ps
`default_nettype none
module test_i2c_master_dma_sequencer;
	logic        sys_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [11:0] avs_address = 12'h000;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        ram_rd, ram_wr, scl_oe, sda_oe, sda_pull, nack_en = 1'b0, irq, route;
	logic [31:0] ram_addr;
	logic [7:0]  ram_wdata, ram_rdata = 8'h00, addr_byte, last_byte;
	logic [7:0]  mem [256];
	logic [31:0] q;
	logic [31:0] psel;
	wire         scl = !scl_oe;
	wire         sda = !(sda_oe | sda_pull);
	int          mismatches = 0;
	int          check_count = 0;
	i2cmd_two_wire_master i2cmd_two_wire_master_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .ram_rd(ram_rd), .ram_wr(ram_wr), .ram_addr(ram_addr),
		.ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .scl_i(scl), .scl_o(), .scl_oe(scl_oe),
		.sda_i(sda), .sda_o(), .sda_oe(sda_oe), .scl_pin_sel(psel), .sda_pin_sel(),
		.pin_route_en(route), .irq(irq));
	i2cmd_slave_model i2cmd_slave_model_inst (.scl(scl), .sda(sda), .nack_en(nack_en),
		.sda_pull(sda_pull), .addr_byte(addr_byte), .last_byte(last_byte));
	// Clock and RAM with one-cycle read latency
	initial forever #5 sys_clk = !sys_clk;
	always @(posedge sys_clk) begin
		if (ram_rd) ram_rdata <= mem[ram_addr[7:0]];
		if (ram_wr) mem[ram_addr[7:0]] <= ram_wdata;
	end
	task automatic final_report;
		$display("checks=%0d mismatches=%0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// One Avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		q = avs_readdata;
		if (n >= 100) begin
			mismatches++;
			final_report();
		end
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	// Poll an event flag under a bounded count
	task automatic wait_ev(input logic [11:0] a);
		int n;
		for (n = 0; n < 9000; n++) begin
			bus(1'b0, a, 32'h0);
			if (q[0] === 1'b1) return;
		end
		mismatches++;
		final_report();
	endtask
	// Main sequence
	initial begin
		mem[16] = 8'h5C;
		mem[17] = 8'h81;
		repeat (5) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		rdchk(12'h7FC, 32'h0);
		rdchk(i2cmd_pkg::OFS_IRQ_MASK, 32'h0);
		bus(1'b1, i2cmd_pkg::OFS_SCL_SEL, 32'h1B);
		bus(1'b1, i2cmd_pkg::OFS_ENABLE, 32'h1);
		chk(psel, 32'h1B);
		chk({31'h0, route}, 32'h1);
		bus(1'b1, i2cmd_pkg::OFS_RATE, {30'h0, i2cmd_pkg::RATE_K400});
		bus(1'b1, i2cmd_pkg::OFS_SLAVE, 32'h3A);
		bus(1'b1, i2cmd_pkg::OFS_TX_PTR, 32'h10);
		bus(1'b1, i2cmd_pkg::OFS_TX_LIMIT, 32'h2);
		bus(1'b1, i2cmd_pkg::OFS_LINKS, 32'h1 << i2cmd_pkg::LNK_FTX_HALT);
		bus(1'b1, i2cmd_pkg::OFS_IRQ_SET, 32'h1 << i2cmd_pkg::IRQ_BIT[i2cmd_pkg::EV_FINTX]);
		bus(1'b1, i2cmd_pkg::OFS_BEGIN_TX, 32'h1);
		wait_ev(i2cmd_pkg::OFS_HALTED);
		chk({24'h0, addr_byte}, 32'h74);
		chk({24'h0, last_byte}, 32'h81);
		rdchk(i2cmd_pkg::OFS_TX_MOVED, 32'h2);
		rdchk(i2cmd_pkg::OFS_FINAL_TX, 32'h1);
		chk({31'h0, irq}, 32'h1);
		bus(1'b1, i2cmd_pkg::OFS_FINAL_TX, 32'h0);
		bus(1'b1, i2cmd_pkg::OFS_HALTED, 32'h0);
		chk({31'h0, irq}, 32'h0);
		$display("test write done");
		bus(1'b1, i2cmd_pkg::OFS_RX_PTR, 32'h40);
		bus(1'b1, i2cmd_pkg::OFS_RX_LIMIT, 32'h2);
		bus(1'b1, i2cmd_pkg::OFS_LINKS, 32'h1 << i2cmd_pkg::LNK_FRX_HALT);
		bus(1'b1, i2cmd_pkg::OFS_BEGIN_RX, 32'h1);
		wait_ev(i2cmd_pkg::OFS_HALTED);
		chk({24'h0, addr_byte}, 32'h75);
		chk({mem[65], mem[64]}, 32'hA5A5);
		rdchk(i2cmd_pkg::OFS_RX_MOVED, 32'h2);
		rdchk(i2cmd_pkg::OFS_FINAL_RX, 32'h1);
		bus(1'b1, i2cmd_pkg::OFS_HALTED, 32'h0);
		$display("test read done");
		// Write paused at its end, halt refused while paused, then a repeated start read
		bus(1'b1, i2cmd_pkg::OFS_RATE, {30'h0, i2cmd_pkg::RATE_K250});
		bus(1'b1, i2cmd_pkg::OFS_LINKS,
			(32'h1 << i2cmd_pkg::LNK_FTX_PAUS) | (32'h1 << i2cmd_pkg::LNK_FRX_HALT));
		bus(1'b1, i2cmd_pkg::OFS_BEGIN_TX, 32'h1);
		wait_ev(i2cmd_pkg::OFS_PAUSED);
		chk({31'h0, scl}, 32'h0);
		bus(1'b1, i2cmd_pkg::OFS_HALT, 32'h1);
		bus(1'b1, i2cmd_pkg::OFS_BEGIN_RX, 32'h1);
		rdchk(i2cmd_pkg::OFS_HALTED, 32'h0);
		bus(1'b1, i2cmd_pkg::OFS_CONTINUE, 32'h1);
		wait_ev(i2cmd_pkg::OFS_HALTED);
		chk({24'h0, addr_byte}, 32'h75);
		rdchk(i2cmd_pkg::OFS_TX_MOVED, 32'h2);
		rdchk(i2cmd_pkg::OFS_RX_MOVED, 32'h2);
		bus(1'b1, i2cmd_pkg::OFS_HALTED, 32'h0);
		$display("test repeated start done");
		nack_en <= 1'b1;
		bus(1'b1, i2cmd_pkg::OFS_LINKS, 32'h0);
		bus(1'b1, i2cmd_pkg::OFS_RATE, {30'h0, i2cmd_pkg::RATE_K100});
		bus(1'b1, i2cmd_pkg::OFS_IRQ_MASK, 32'h1 << i2cmd_pkg::IRQ_BIT[i2cmd_pkg::EV_FAULT]);
		bus(1'b1, i2cmd_pkg::OFS_BEGIN_TX, 32'h1);
		wait_ev(i2cmd_pkg::OFS_FAULT);
		chk({31'h0, irq}, 32'h1);
		rdchk(i2cmd_pkg::OFS_HALTED, 32'h0);
		rdchk(i2cmd_pkg::OFS_FAULT_SRC, 32'h1 << i2cmd_pkg::FC_ADDR_NACK);
		bus(1'b1, i2cmd_pkg::OFS_HALT, 32'h1);
		wait_ev(i2cmd_pkg::OFS_HALTED);
		bus(1'b1, i2cmd_pkg::OFS_ENABLE, 32'h0);
		chk({31'h0, route}, 32'h0);
		$display("test fault done");
		final_report();
	end
endmodule
`default_nettype wire
